// ===== hdl/auc_pkg.sv
package auc_pkg;
  localparam int unsigned       AUC_DATA_W      = 9;
  localparam int unsigned       AUC_FIFO_DEPTH  = 16;
  localparam int unsigned       AUC_SYNC_STAGES = 3;
  localparam int unsigned       AUC_NUM_PINS    = 4;
  localparam logic [3:0]        AUC_OS_LAST     = 4'hF;
  localparam logic [3:0]        AUC_OS_MID      = 4'h7;
  localparam logic [2:0]        AUC_DIV8_LAST   = 3'h7;
  localparam logic [4:0]        AUC_DIV32_LAST  = 5'h1F;
  localparam logic [8:0]        AUC_MASK7       = 9'h07F;
  localparam logic [8:0]        AUC_MASK8       = 9'h0FF;
  localparam logic [8:0]        AUC_MASK9       = 9'h1FF;
  localparam logic [3:0]        AUC_BITS7       = 4'h7;
  localparam logic [3:0]        AUC_BITS8       = 4'h8;
  localparam logic [3:0]        AUC_BITS9       = 4'h9;
  localparam logic              AUC_LINE_IDLE   = 1'b1;

  typedef enum logic [1:0] {
    AUC_LEN7 = 2'h0,
    AUC_LEN8 = 2'h1,
    AUC_LEN9 = 2'h2
  } auc_len_t;

  typedef enum logic [1:0] {
    AUC_SRC_UNDIV = 2'h0,
    AUC_SRC_DIV8  = 2'h1,
    AUC_SRC_DIV32 = 2'h2,
    AUC_SRC_LOW   = 2'h3
  } auc_src_t;

  typedef enum logic [1:0] {
    AUC_FLOW_OFF = 2'h0,
    AUC_FLOW_CTS = 2'h1,
    AUC_FLOW_RTS = 2'h2
  } auc_flow_t;

  typedef enum logic [4:0] {
    AUC_IDLE  = 5'h01,
    AUC_START = 5'h02,
    AUC_DATA  = 5'h04,
    AUC_PAR   = 5'h08,
    AUC_STOP  = 5'h10
  } auc_st_t;

  typedef struct packed {
    auc_len_t   char_len;
    logic       two_stop;
    logic       parity_en;
    logic       parity_odd;
    logic       clock_direction_select;
    auc_src_t   src_sel;
    auc_flow_t  flow_mode;
    logic       transmit_irq_source_select;
    logic [7:0] bit_rate_divisor;
  } auc_cfg_t;

  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } auc_err_t;
endpackage : auc_pkg

// ===== hdl/auc_fifo.sv
`timescale 1ns/10ps
module auc_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready,
  output logic              out_valid
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic [W-1:0]  out_reg, out_next;
  logic          ov_reg, ov_next;
  logic          push, pop;

  assign in_ready  = cnt_reg != (AW+1)'(D);
  assign out_valid = ov_reg;
  assign out_data  = out_reg;
  assign push      = in_valid && in_ready;
  // output stage refills whenever it is empty or being drained
  assign pop       = (cnt_reg != '0) && (!ov_reg || out_ready);

  always_comb begin
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    out_next = pop ? mem[rd_reg] : out_reg;
    ov_next  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      out_reg <= '0;
      ov_reg  <= 1'b0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      ov_reg  <= ov_next;
    end
  end
endmodule : auc_fifo

// ===== hdl/auc_uart.sv
`timescale 1ns/10ps
module auc_uart (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire auc_pkg::auc_cfg_t cfg,
  input  wire logic              transmit_enable_bit,
  input  wire logic              receive_enable_bit,
  input  wire logic [8:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic                   transmit_buffer_empty_flag,
  output logic                   tx_busy,
  output logic [8:0]             receive_buffer,
  output logic                   rx_full,
  input  wire logic              rx_read,
  output auc_pkg::auc_err_t      err,
  input  wire logic              err_clear,
  output logic                   tx_irq,
  output logic                   rx_irq,
  output logic                   txd,
  input  wire logic              rxd,
  input  wire logic              external_clock_pin,
  input  wire logic              low_speed_clock,
  input  wire logic              flow_control_pin_in,
  output logic                   flow_control_pin_out,
  output logic                   flow_control_pin_oe_n
);

  function automatic logic [8:0] char_mask(auc_pkg::auc_len_t l);
    unique case (l)
      auc_pkg::AUC_LEN7: char_mask = auc_pkg::AUC_MASK7;
      auc_pkg::AUC_LEN8: char_mask = auc_pkg::AUC_MASK8;
      auc_pkg::AUC_LEN9: char_mask = auc_pkg::AUC_MASK9;
      default:           char_mask = auc_pkg::AUC_MASK8;
    endcase
  endfunction : char_mask

  function automatic logic [3:0] char_last(auc_pkg::auc_len_t l);
    unique case (l)
      auc_pkg::AUC_LEN7: char_last = auc_pkg::AUC_BITS7 - 4'h1;
      auc_pkg::AUC_LEN8: char_last = auc_pkg::AUC_BITS8 - 4'h1;
      auc_pkg::AUC_LEN9: char_last = auc_pkg::AUC_BITS9 - 4'h1;
      default:           char_last = auc_pkg::AUC_BITS8 - 4'h1;
    endcase
  endfunction : char_last

  // pins: 0 rxd, 1 external clock, 2 low-speed clock, 3 flow pin
  localparam int unsigned NP = auc_pkg::AUC_NUM_PINS;
  logic [NP-1:0] pin_raw, filt_reg, filt_next, prev_reg;
  logic [auc_pkg::AUC_SYNC_STAGES-1:0] sync_reg [NP];
  assign pin_raw = {flow_control_pin_in, low_speed_clock,
                    external_clock_pin, rxd};

  for (genvar i = 0; i < NP; i++) begin : g_sync
    // a change counts only once the last two stages agree
    assign filt_next[i] = (sync_reg[i][1] == sync_reg[i][2]) ?
                          sync_reg[i][2] : filt_reg[i];
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sync_reg[i] <= '1;
        filt_reg[i] <= 1'b1;
        prev_reg[i] <= 1'b1;
      end else begin
        sync_reg[i] <= {sync_reg[i][1:0], pin_raw[i]};
        filt_reg[i] <= filt_next[i];
        prev_reg[i] <= filt_reg[i];
      end
    end
  end

  logic rx_f, cts_f, ext_edge, low_edge;
  assign rx_f     = filt_reg[0];
  assign cts_f    = filt_reg[3];
  assign ext_edge = filt_reg[1] && !prev_reg[1];
  assign low_edge = filt_reg[2] && !prev_reg[2];

  // bit-rate generator
  logic [4:0] pre_reg, pre_next;
  logic [7:0] div_reg, div_next;
  logic       int_tick, src_tick, os_tick;
  always_comb begin
    pre_next = pre_reg + 5'h01;
    unique case (cfg.src_sel)
      auc_pkg::AUC_SRC_UNDIV: int_tick = 1'b1;
      auc_pkg::AUC_SRC_DIV8:  int_tick = pre_reg[2:0] == auc_pkg::AUC_DIV8_LAST;
      auc_pkg::AUC_SRC_DIV32: int_tick = pre_reg == auc_pkg::AUC_DIV32_LAST;
      auc_pkg::AUC_SRC_LOW:   int_tick = low_edge;
    endcase
    src_tick = cfg.clock_direction_select ? ext_edge : int_tick;
    // a divisor lowered while idle must not wait for an 8-bit wrap
    os_tick  = src_tick && (div_reg >= cfg.bit_rate_divisor);
    div_next = !src_tick ? div_reg : (os_tick ? 8'h00 : div_reg + 8'h01);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 5'h00;
      div_reg <= 8'h00;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
    end
  end

  // transmit path: fifo feeds the transmit buffer
  logic [8:0] fifo_data;
  logic       fifo_valid, tb_full_reg, tb_full_next;
  logic [8:0] tb_reg, tb_next;
  auc_fifo #(.W(auc_pkg::AUC_DATA_W), .D(auc_pkg::AUC_FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_ready (!tb_full_reg),
    .out_valid (fifo_valid)
  );

  auc_pkg::auc_st_t tx_st_reg, tx_st_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next, tx_bit_reg, tx_bit_next;
  logic [8:0] tx_sh_reg, tx_sh_next;
  logic       tx_par_reg, tx_par_next, tx_stp_reg, tx_stp_next;
  logic       txd_reg, txd_next, tx_irq_reg, tx_irq_next;
  logic       cts_ok, tx_load, tx_end, tx_done;

  // flow pin ignored unless CTS is chosen
  assign cts_ok  = (cfg.flow_mode != auc_pkg::AUC_FLOW_CTS) || !cts_f;
  assign tx_load = (tx_st_reg == auc_pkg::AUC_IDLE) && transmit_enable_bit
                   && tb_full_reg && cts_ok;
  assign tx_end  = os_tick && (tx_cnt_reg == auc_pkg::AUC_OS_LAST);
  assign tx_done = tx_end && (tx_st_reg == auc_pkg::AUC_STOP) &&
                   (!cfg.two_stop || tx_stp_reg);

  always_comb begin
    tb_full_next = tx_load ? 1'b0 : (fifo_valid ? 1'b1 : tb_full_reg);
    tb_next      = (!tb_full_reg && fifo_valid) ? fifo_data : tb_reg;
    tx_st_next   = tx_st_reg;
    tx_cnt_next  = os_tick ? tx_cnt_reg + 4'h1 : tx_cnt_reg;
    tx_bit_next  = tx_bit_reg;
    tx_sh_next   = tx_sh_reg;
    tx_par_next  = tx_par_reg;
    tx_stp_next  = tx_stp_reg;
    tx_irq_next  = (tx_load && !cfg.transmit_irq_source_select) ||
                   (tx_done && cfg.transmit_irq_source_select);
    unique case (tx_st_reg)
      auc_pkg::AUC_IDLE: begin
        tx_cnt_next = 4'h0;
        if (tx_load) begin
          tx_st_next  = auc_pkg::AUC_START;
          tx_sh_next  = tb_reg & char_mask(cfg.char_len);
          tx_par_next = ^(tb_reg & char_mask(cfg.char_len))
                        ^ cfg.parity_odd;
        end
      end
      auc_pkg::AUC_START: if (tx_end) begin
        tx_st_next  = auc_pkg::AUC_DATA;
        tx_bit_next = 4'h0;
      end
      auc_pkg::AUC_DATA: if (tx_end) begin
        tx_sh_next  = {1'b0, tx_sh_reg[8:1]};
        tx_bit_next = tx_bit_reg + 4'h1;
        tx_stp_next = 1'b0;
        if (tx_bit_reg == char_last(cfg.char_len)) begin
          tx_st_next = cfg.parity_en ? auc_pkg::AUC_PAR
                                     : auc_pkg::AUC_STOP;
        end
      end
      auc_pkg::AUC_PAR: if (tx_end) begin
        tx_st_next = auc_pkg::AUC_STOP;
      end
      auc_pkg::AUC_STOP: if (tx_end) begin
        tx_stp_next = 1'b1;
        if (tx_done) begin
          tx_st_next = auc_pkg::AUC_IDLE;
        end
      end
    endcase
    unique case (tx_st_next)
      auc_pkg::AUC_START: txd_next = 1'b0;
      auc_pkg::AUC_DATA:  txd_next = tx_sh_next[0];
      auc_pkg::AUC_PAR:   txd_next = tx_par_next;
      default:            txd_next = auc_pkg::AUC_LINE_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tb_full_reg <= 1'b0;
      tb_reg      <= 9'h000;
      tx_st_reg   <= auc_pkg::AUC_IDLE;
      tx_cnt_reg  <= 4'h0;
      tx_bit_reg  <= 4'h0;
      tx_sh_reg   <= 9'h000;
      tx_par_reg  <= 1'b0;
      tx_stp_reg  <= 1'b0;
      txd_reg     <= auc_pkg::AUC_LINE_IDLE;
      tx_irq_reg  <= 1'b0;
    end else begin
      tb_full_reg <= tb_full_next;
      tb_reg      <= tb_next;
      tx_st_reg   <= tx_st_next;
      tx_cnt_reg  <= tx_cnt_next;
      tx_bit_reg  <= tx_bit_next;
      tx_sh_reg   <= tx_sh_next;
      tx_par_reg  <= tx_par_next;
      tx_stp_reg  <= tx_stp_next;
      txd_reg     <= txd_next;
      tx_irq_reg  <= tx_irq_next;
    end
  end

  // receive path
  auc_pkg::auc_st_t rx_st_reg, rx_st_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next, rx_bit_reg, rx_bit_next;
  logic [8:0] rx_sh_reg, rx_sh_next, rb_reg, rb_next;
  logic       rx_stp_reg, rx_stp_next, rx_pe_reg, rx_pe_next;
  logic       rx_fe_reg, rx_fe_next, full_reg, full_next;
  logic       rx_irq_reg, rx_irq_next, rx_end, rx_last, ovr_set;
  auc_pkg::auc_err_t err_reg, err_next;

  // counter restarts at mid-start, so each later wrap lands mid-bit
  assign rx_end = os_tick && (rx_cnt_reg == auc_pkg::AUC_OS_LAST);

  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_cnt_next = os_tick ? rx_cnt_reg + 4'h1 : rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_stp_next = rx_stp_reg;
    rx_pe_next  = rx_pe_reg;
    rx_fe_next  = rx_fe_reg;
    rx_last     = 1'b0;
    ovr_set     = 1'b0;
    unique case (rx_st_reg)
      auc_pkg::AUC_IDLE: begin
        rx_cnt_next = 4'h0;
        if (receive_enable_bit && prev_reg[0] && !rx_f) begin
          rx_st_next = auc_pkg::AUC_START;
        end
      end
      auc_pkg::AUC_START: if (os_tick &&
                              rx_cnt_reg == auc_pkg::AUC_OS_MID) begin
        rx_cnt_next = 4'h0;
        rx_bit_next = 4'h0;
        rx_sh_next  = 9'h000;
        rx_pe_next  = 1'b0;
        rx_fe_next  = 1'b0;
        rx_stp_next = 1'b0;
        // glitch shorter than half a bit is dropped
        rx_st_next  = rx_f ? auc_pkg::AUC_IDLE : auc_pkg::AUC_DATA;
      end
      auc_pkg::AUC_DATA: if (rx_end) begin
        rx_sh_next[rx_bit_reg] = rx_f;
        rx_bit_next = rx_bit_reg + 4'h1;
        if (rx_bit_reg == char_last(cfg.char_len)) begin
          rx_st_next = cfg.parity_en ? auc_pkg::AUC_PAR
                                     : auc_pkg::AUC_STOP;
          ovr_set    = !cfg.parity_en && !cfg.two_stop && full_reg;
        end
      end
      auc_pkg::AUC_PAR: if (rx_end) begin
        rx_pe_next = (^rx_sh_reg ^ rx_f) != cfg.parity_odd;
        rx_st_next = auc_pkg::AUC_STOP;
        ovr_set    = !cfg.two_stop && full_reg;
      end
      auc_pkg::AUC_STOP: if (rx_end) begin
        rx_fe_next  = rx_fe_reg || !rx_f;
        rx_stp_next = 1'b1;
        if (cfg.two_stop && !rx_stp_reg) begin
          ovr_set = full_reg;
        end else begin
          rx_last    = 1'b1;
          rx_st_next = auc_pkg::AUC_IDLE;
        end
      end
    endcase
    rx_irq_next = rx_last && !full_reg;
    rb_next     = rx_irq_next ? rx_sh_next : rb_reg;
    full_next   = rx_irq_next || (full_reg && !rx_read);
    // set beats a clear arriving in the same cycle
    err_next.overrun = ovr_set || (err_reg.overrun && !err_clear);
    err_next.framing = (rx_last && rx_fe_next) ||
                       (err_reg.framing && !err_clear);
    err_next.parity  = (rx_last && rx_pe_reg && cfg.parity_en) ||
                       (err_reg.parity && !err_clear);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg  <= auc_pkg::AUC_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg  <= 9'h000;
      rx_stp_reg <= 1'b0;
      rx_pe_reg  <= 1'b0;
      rx_fe_reg  <= 1'b0;
      rb_reg     <= 9'h000;
      full_reg   <= 1'b0;
      rx_irq_reg <= 1'b0;
      err_reg    <= '0;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg  <= rx_sh_next;
      rx_stp_reg <= rx_stp_next;
      rx_pe_reg  <= rx_pe_next;
      rx_fe_reg  <= rx_fe_next;
      rb_reg     <= rb_next;
      full_reg   <= full_next;
      rx_irq_reg <= rx_irq_next;
      err_reg    <= err_next;
    end
  end

  assign txd                        = txd_reg;
  assign tx_irq                     = tx_irq_reg;
  assign rx_irq                     = rx_irq_reg;
  assign transmit_buffer_empty_flag = !tb_full_reg;
  assign tx_busy                    = tx_st_reg != auc_pkg::AUC_IDLE;
  assign receive_buffer             = rb_reg;
  assign rx_full                    = full_reg;
  assign err                        = err_reg;
  // ready to receive drives the pin low
  assign flow_control_pin_out   = full_reg || !receive_enable_bit;
  assign flow_control_pin_oe_n  = cfg.flow_mode != auc_pkg::AUC_FLOW_RTS;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_tx_start_gate: assert property (tx_st_reg == auc_pkg::AUC_IDLE &&
    tx_st_next == auc_pkg::AUC_START |-> transmit_enable_bit &&
    !transmit_buffer_empty_flag && cts_ok) else $error("bad tx start");
  a_cts_blocks: assert property (cfg.flow_mode == auc_pkg::AUC_FLOW_CTS &&
    cts_f && !tx_busy |=> !tx_busy) else $error("sent against cts");
  a_start_low: assert property ($rose(tx_st_reg == auc_pkg::AUC_START)
    |-> !txd) else $error("start bit not low");
  a_stop_high: assert property (tx_st_reg == auc_pkg::AUC_STOP |-> txd)
    else $error("stop bit not high");
  a_irq_on_load: assert property (tx_load &&
    !cfg.transmit_irq_source_select |=> tx_irq ##1 !tx_irq)
    else $error("no tx irq at load");
  a_irq_on_done: assert property (tx_done &&
    cfg.transmit_irq_source_select |=> tx_irq && !tx_busy)
    else $error("no tx irq at end");
  a_rx_irq_full: assert property (rx_irq |-> rx_full && !$past(rx_full))
    else $error("rx irq without load");
  a_rx_needs_en: assert property ($rose(rx_st_reg == auc_pkg::AUC_START)
    |-> $past(receive_enable_bit)) else $error("rx start disabled");
  a_rts_level: assert property (cfg.flow_mode == auc_pkg::AUC_FLOW_RTS
    && rx_full |-> !flow_control_pin_oe_n && flow_control_pin_out)
    else $error("rts wrong");

  c_tx_frame: cover property (tx_done);
  c_rx_word:  cover property (rx_irq);
  c_overrun:  cover property (ovr_set);
  c_frame_err: cover property ($rose(err.framing));
endmodule : auc_uart

// ===== dv/auc_remote.sv
`timescale 1ns/10ps
module auc_remote (
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd,
  input  wire integer bit_cyc,
  input  wire integer nbits,
  output logic [9:0] got_word,
  output int        got_cnt
);
  logic [9:0] w;

  initial begin
    rxd = 1'b1;
    got_word = 10'h000;
    got_cnt = 0;
  end

  // samples are taken mid-bit so edge skew of a cycle or two is harmless
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clock);
    if (txd === 1'b0) begin
      w = 10'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge clock);
        w[i] = txd;
      end
      repeat (bit_cyc) @(posedge clock);
      got_word = w;
      got_cnt++;
    end
  end

  task automatic send(input logic [9:0] bits, input int n, input logic stp);
    @(posedge clock);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_cyc) @(posedge clock);
    end
    rxd <= stp;
    repeat (bit_cyc) @(posedge clock);
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge clock);
  endtask : send

  // too short to survive the mid-bit start check
  task automatic glitch(input int n);
    @(posedge clock);
    rxd <= 1'b0;
    repeat (n) @(posedge clock);
    rxd <= 1'b1;
    repeat (40) @(posedge clock);
  endtask : glitch
endmodule : auc_remote

// ===== dv/test_auc_uart.sv
`timescale 1ns/10ps
module test_auc_uart;
  logic clock, rst_n, transmit_enable_bit, receive_enable_bit, tx_valid;
  logic tx_ready, transmit_buffer_empty_flag, tx_busy, rx_full, rx_read;
  logic err_clear, tx_irq, rx_irq, txd, rxd, external_clock_pin;
  logic low_speed_clock, flow_control_pin_in, flow_control_pin_out;
  logic flow_control_pin_oe_n, txd_q = 1'b1;
  logic [8:0] tx_data, receive_buffer;
  logic [9:0] got_word;
  auc_pkg::auc_cfg_t cfg;
  auc_pkg::auc_err_t err;
  int error_cnt = 0, checks = 0, sent = 0, bc = 16, nb, got_cnt, cyc = 0;
  int fall_t = 0, prev_fall = 0, rise_t = 0, irq_t = 0, rx_irqs = 0;
  int rsrc[6] = '{0, 0, 1, 2, 3, 0};
  int rdiv[6] = '{0, 3, 1, 0, 0, 0};
  int rbc[6] = '{16, 64, 256, 512, 320, 192};

  auc_uart i_dut (.clock, .rst_n, .cfg, .transmit_enable_bit,
    .receive_enable_bit, .tx_data, .tx_valid, .tx_ready,
    .transmit_buffer_empty_flag, .tx_busy, .receive_buffer, .rx_full,
    .rx_read, .err, .err_clear, .tx_irq, .rx_irq, .txd, .rxd,
    .external_clock_pin, .low_speed_clock, .flow_control_pin_in,
    .flow_control_pin_out, .flow_control_pin_oe_n);
  auc_remote i_remote (.clock, .txd, .rxd, .bit_cyc(bc), .nbits(nb),
    .got_word, .got_cnt);

  // remote also samples the parity bit when it is on
  always_comb nb = ((cfg.char_len == auc_pkg::AUC_LEN7) ? 7 :
    (cfg.char_len == auc_pkg::AUC_LEN9) ? 9 : 8) + int'(cfg.parity_en);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // pin clocks are free running and off the sampling edge
  initial begin
    low_speed_clock = 1'b0;
    forever #100 low_speed_clock = ~low_speed_clock;
  end
  initial begin
    external_clock_pin = 1'b0;
    forever #60 external_clock_pin = ~external_clock_pin;
  end

  always @(negedge clock) begin
    cyc++;
    if (txd !== txd_q) begin
      if (txd === 1'b0) begin
        prev_fall = fall_t;
        fall_t = cyc;
      end else rise_t = cyc;
    end
    txd_q = txd;
    if (tx_irq === 1'b1) irq_t = cyc;
    if (rx_irq === 1'b1) rx_irqs++;
  end

  task check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task put(input logic [8:0] w);
    @(posedge clock);
    tx_data <= w;
    tx_valid <= 1'b1;
    @(negedge clock);
    for (int k = 0; k < 100 && tx_ready !== 1'b1; k++) @(negedge clock);
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask : put

  task wait_tx;
    for (int k = 0; k < 20000 && got_cnt != sent; k++) @(negedge clock);
    check("frames sent", got_cnt, sent);
    tick(bc);
  endtask : wait_tx

  task wait_rx;
    for (int k = 0; k < 3000 && rx_full !== 1'b1; k++) @(negedge clock);
  endtask : wait_rx

  task clr;
    @(posedge clock);
    rx_read <= 1'b1;
    err_clear <= 1'b1;
    @(posedge clock);
    rx_read <= 1'b0;
    err_clear <= 1'b0;
  endtask : clr

  task t_format;
    logic [9:0] d, f;
    for (int l = 0; l < 3; l++) begin
      for (int p = 0; p < 3; p++) begin
        @(posedge clock);
        cfg.char_len <= auc_pkg::auc_len_t'(l);
        cfg.parity_en <= (p != 0);
        cfg.parity_odd <= (p == 2);
        d = (10'h1A5 >> p) & (10'h3FF >> (3 - l));
        f = d;
        if (p != 0) f[7 + l] = ^d ^ (p == 2);
        put(d[8:0]);
        sent++;
        wait_tx;
        check("tx frame", got_word, f);
        i_remote.send(f, 7 + l + int'(p != 0), 1'b1);
        wait_rx;
        check("rx word", receive_buffer, d);
        check("rx err", err, 3'h0);
        clr;
      end
    end
  endtask : t_format

  task t_rxerr;
    int n;
    @(posedge clock);
    cfg.char_len <= auc_pkg::AUC_LEN8;
    cfg.parity_odd <= 1'b0;
    i_remote.send(10'h103, 9, 1'b1);
    wait_rx;
    check("parity err", err, 3'h1);
    clr;
    i_remote.send(10'h003, 9, 1'b0);
    wait_rx;
    check("framing err", err, 3'h2);
    clr;
    n = rx_irqs;
    i_remote.send(10'h003, 9, 1'b1);
    i_remote.send(10'h00F, 9, 1'b1);
    check("overrun", {err, receive_buffer}, {3'h4, 9'h003});
    check("rx irqs", rx_irqs - n, 1);
    clr;
    i_remote.glitch(4);
    check("glitch", rx_full, 1'h0);
    receive_enable_bit <= 1'b0;
    i_remote.send(10'h003, 9, 1'b1);
    check("rx off", rx_full, 1'h0);
    receive_enable_bit <= 1'b1;
    cfg.parity_en <= 1'b0;
  endtask : t_rxerr

  task t_flow;
    @(posedge clock);
    cfg.flow_mode <= auc_pkg::AUC_FLOW_RTS;
    tick(2);
    check("rts idle", {flow_control_pin_oe_n, flow_control_pin_out}, 2'h0);
    i_remote.send(10'h055, 8, 1'b1);
    check("rts full", flow_control_pin_out, 1'h1);
    clr;
    flow_control_pin_in <= 1'b1;
    cfg.flow_mode <= auc_pkg::AUC_FLOW_CTS;
    transmit_enable_bit <= 1'b0;
    tick(2);
    check("rts off", flow_control_pin_oe_n, 1'h1);
    put(9'h0FF);
    tick(200);
    check("te gate", {got_cnt == sent, transmit_buffer_empty_flag}, 2'h2);
    transmit_enable_bit <= 1'b1;
    tick(200);
    check("cts high", got_cnt, sent);
    flow_control_pin_in <= 1'b0;
    sent++;
    wait_tx;
    flow_control_pin_in <= 1'b1;
    cfg.flow_mode <= auc_pkg::AUC_FLOW_OFF;
    put(9'h0FF);
    sent++;
    wait_tx;
    flow_control_pin_in <= 1'b0;
  endtask : t_flow

  task t_irq;
    put(9'h0FF);
    sent++;
    wait_tx;
    check("irq at start", irq_t - fall_t, 0);
    cfg.transmit_irq_source_select <= 1'b1;
    put(9'h0FF);
    sent++;
    wait_tx;
    tick(4);
    check("irq at end", (irq_t - fall_t) inside {160, 161}, 1);
    check("idle after", tx_busy, 1'h0);
    cfg.transmit_irq_source_select <= 1'b0;
  endtask : t_irq

  task t_stops;
    @(posedge clock);
    transmit_enable_bit <= 1'b0;
    cfg.two_stop <= 1'b1;
    put(9'h0FF);
    put(9'h0FF);
    transmit_enable_bit <= 1'b1;
    sent += 2;
    wait_tx;
    check("two stops", (fall_t - prev_fall) inside {[176:178]}, 1);
    tick(40);
    cfg.two_stop <= 1'b0;
  endtask : t_stops

  // one low data bit between two high ones gives an exact bit width
  task t_rate;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      cfg.src_sel <= auc_pkg::auc_src_t'(rsrc[i]);
      cfg.clock_direction_select <= (i == 5);
      cfg.bit_rate_divisor <= 8'(rdiv[i]);
      bc <= rbc[i];
      put(9'h0FD);
      sent++;
      wait_tx;
      check("rate word", got_word, 10'h0FD);
      check("bit width", rise_t - fall_t, rbc[i]);
    end
    cfg.src_sel <= auc_pkg::AUC_SRC_UNDIV;
    cfg.clock_direction_select <= 1'b0;
    cfg.bit_rate_divisor <= 8'h00;
    bc <= 16;
  endtask : t_rate

  task t_fill;
    int k;
    @(posedge clock);
    transmit_enable_bit <= 1'b0;
    tx_valid <= 1'b1;
    tx_data <= 9'h000;
    k = 0;
    repeat (40) begin
      @(negedge clock);
      if (tx_ready === 1'b1) k++;
      @(posedge clock);
      tx_data <= 9'(k);
    end
    tx_valid <= 1'b0;
    check("fill depth", k, 18);
    transmit_enable_bit <= 1'b1;
    sent += 18;
    wait_tx;
    check("last word", got_word, 10'h011);
  endtask : t_fill

  initial begin
    #600000;
    error_cnt++;
    stop_test;
  end

  initial begin
    rst_n = 1'b0;
    cfg = '0;
    cfg.char_len = auc_pkg::AUC_LEN8;
    transmit_enable_bit = 1'b1;
    receive_enable_bit = 1'b1;
    tx_data = 9'h000;
    tx_valid = 1'b0;
    rx_read = 1'b0;
    err_clear = 1'b0;
    flow_control_pin_in = 1'b0;
    repeat (10) @(negedge clock);
    check("reset", {txd, transmit_buffer_empty_flag, rx_full, err, tx_ready, tx_irq, rx_irq}, 9'h184);
    @(posedge clock);
    rst_n <= 1'b1;
    tick(5);
    t_format;
    t_rxerr;
    t_flow;
    t_irq;
    t_stops;
    t_rate;
    t_fill;
    stop_test;
  end
endmodule : test_auc_uart
